// *** bench/mii_mac_model.sv ***
// mac model: sends transmit nibbles in step with the tx clock the phy supplies
// assumes it is handed the block's tx clock and the system clock beside it
`timescale 1ns/10ps
module mii_mac_model (
  input wire logic i_clk_sys,
  input wire logic i_tx_clk,
  output logic [3:0] o_txd,
  output logic o_tx_en
);
  // ==========================================================================
  // idle at start
  initial begin
    o_txd = 4'h0;
    o_tx_en = 1'b0;
  end
  // one nibble a tx clock, changed just after the rise so it is stable long before the next
  // capture; idle data is inverted so a stale nibble never looks fresh
  task send(input logic [3:0] nib, input logic en);
    @(posedge i_tx_clk);
    @(negedge i_clk_sys);
    o_tx_en = en;
    o_txd = en ? nib : ~o_txd;
  endtask
endmodule

// *** bench/mii_phy_side_assertions.sv ***
// checker: mii clock rates, rx output timing, crs and col, loopback line gating
// assumes a bind into mii_phy_side and sight of its ports only
`timescale 1ns/10ps
module mii_phy_side_assertions (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_speed_100,
  input wire logic i_full_duplex,
  input wire logic i_autoneg_en,
  input wire logic i_test_loopback,
  input wire logic i_tx_en,
  input wire logic i_line_rx_carrier,
  input wire logic o_tx_clk,
  input wire logic o_rx_clk,
  input wire logic [3:0] o_rxd,
  input wire logic o_rx_dv,
  input wire logic o_rx_er,
  input wire logic o_crs,
  input wire logic o_col,
  input wire logic o_line_tx_stb,
  input wire logic o_line_tx_en
);
  // ==========================================================================
  // helpers: cycles since the last clock toggle, and where the clock fell
  logic [7:0] half_q;
  logic seen_q;
  logic clk_q;
  logic fell_q;
  wire tl_on = i_test_loopback && i_full_duplex && !i_autoneg_en;
  wire toggle = o_rx_clk != clk_q;
  wire fell = clk_q && !o_rx_clk;
  // the first toggle after reset only arms the rate check, its count is partial
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      half_q <= 8'h00;
      seen_q <= 1'b0;
      clk_q <= 1'b0;
      fell_q <= 1'b0;
    end else begin
      half_q <= toggle ? 8'h00 : half_q + 8'h01;
      seen_q <= seen_q || toggle;
      clk_q <= o_rx_clk;
      fell_q <= fell;
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_same_clk; o_tx_clk == o_rx_clk; endproperty
  a_same_clk: assert property (p_same_clk) else $error("tx and rx clocks differ");
  property p_clk_rate; toggle && seen_q |-> half_q == (i_speed_100 ? 8'h03 : 8'h27); endproperty
  a_clk_rate: assert property (p_clk_rate) else $error("mii clock half period wrong");
  property p_rx_sync; !$stable({o_rxd, o_rx_dv, o_rx_er}) |-> fell || fell_q; endproperty
  a_rx_sync: assert property (p_rx_sync) else $error("rx outputs moved off the clock");
  property p_no_col_full; i_full_duplex |-> !o_col; endproperty
  a_no_col_full: assert property (p_no_col_full) else $error("collision in full duplex");
  property p_col_on; (!i_full_duplex && i_line_rx_carrier && i_tx_en) [*4] |-> o_col; endproperty
  a_col_on: assert property (p_col_on) else $error("collision not flagged");
  property p_col_off; (!i_tx_en) [*4] |-> !o_col; endproperty
  a_col_off: assert property (p_col_off) else $error("collision without transmit");
  property p_crs_rx; (i_line_rx_carrier && !tl_on) [*4] |-> o_crs; endproperty
  a_crs_rx: assert property (p_crs_rx) else $error("carrier sense missing on receive");
  property p_crs_full; (i_full_duplex && (!i_line_rx_carrier || tl_on)) [*4] |-> !o_crs; endproperty
  a_crs_full: assert property (p_crs_full) else $error("carrier sense on full duplex send");
  property p_crs_half; (!i_full_duplex && i_tx_en) [*4] |-> o_crs; endproperty
  a_crs_half: assert property (p_crs_half) else $error("carrier sense missing on send");
  property p_tl_line; tl_on [*2] |-> !o_line_tx_en && !o_line_tx_stb; endproperty
  a_tl_line: assert property (p_tl_line) else $error("line active in test loopback");
  property p_stb_gap; o_line_tx_stb |=> (!o_line_tx_stb) [*7]; endproperty
  a_stb_gap: assert property (p_stb_gap) else $error("line symbols too close");
endmodule

bind mii_phy_side mii_phy_side_assertions chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_speed_100(i_speed_100),
  .i_full_duplex(i_full_duplex), .i_autoneg_en(i_autoneg_en), .i_test_loopback(i_test_loopback),
  .i_tx_en(i_tx_en), .i_line_rx_carrier(i_line_rx_carrier), .o_tx_clk(o_tx_clk), .o_rx_clk(o_rx_clk),
  .o_rxd(o_rxd), .o_rx_dv(o_rx_dv), .o_rx_er(o_rx_er), .o_crs(o_crs), .o_col(o_col),
  .o_line_tx_stb(o_line_tx_stb), .o_line_tx_en(o_line_tx_en));

// *** bench/test_mii_phy_side.sv ***
// testbench: mac model on the mii, line receive driven here, a table of modes
// assumes the design, its checker bind and the mac model are compiled first
`timescale 1ns/10ps
`include "mii_phy_regs.svh"
module test_mii_phy_side;
  // ==========================================================================
  // signals
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_speed_100 = 1'b0, i_full_duplex = 1'b0, i_autoneg_en = 1'b0, i_test_loopback = 1'b0;
  logic i_oploop_disable = 1'b0, i_line_rx_clk = 1'b0, i_line_rx_carrier = 1'b0;
  logic [4:0] i_line_rx_sym = 5'h00;
  logic [3:0] txd, o_rxd;
  logic [4:0] o_line_tx_sym;
  logic tx_en, o_tx_clk, o_rx_clk, o_rx_dv, o_rx_er, o_crs, o_col, o_line_tx_stb, o_line_tx_en, o_line_rx_ready;
  logic [4:0] exp_rx[$];
  logic [3:0] exp_ln[$];
  logic [4:0] exp_sym[$];
  logic [4:0] lsy;
  logic [`SCR_WIDTH-1:0] tk, rk;
  // data code groups, indexed by nibble
  logic [4:0] code5b[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16,
    5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  integer err_count = 0, n_checks = 0, seed = 50;
  logic lax = 1'b0, saw_full = 1'b0, stb_q = 1'b0;
  wire tl_on = i_test_loopback & i_full_duplex & ~i_autoneg_en;
  // modes: speed, full, autoneg, test loop, op loop off, loopback expected
  logic [5:0] modes[8] = '{6'h35, 6'h15, 6'h01, 6'h02, 6'h20, 6'h10, 6'h3C, 6'h06};

  always #2.5 i_clk_sys = ~i_clk_sys;

  mii_phy_side DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_speed_100(i_speed_100), .i_full_duplex(i_full_duplex),
    .i_autoneg_en(i_autoneg_en), .i_test_loopback(i_test_loopback), .i_oploop_disable(i_oploop_disable),
    .o_tx_clk(o_tx_clk), .o_rx_clk(o_rx_clk), .i_txd(txd), .i_tx_en(tx_en), .o_rxd(o_rxd), .o_rx_dv(o_rx_dv),
    .o_rx_er(o_rx_er), .o_crs(o_crs), .o_col(o_col), .o_line_tx_sym(o_line_tx_sym), .o_line_tx_stb(o_line_tx_stb),
    .o_line_tx_en(o_line_tx_en), .i_line_rx_clk(i_line_rx_clk), .i_line_rx_sym(i_line_rx_sym),
    .i_line_rx_carrier(i_line_rx_carrier), .o_line_rx_ready(o_line_rx_ready));
  mii_mac_model mac (.i_clk_sys(i_clk_sys), .i_tx_clk(o_tx_clk), .o_txd(txd), .o_tx_en(tx_en));

  // ==========================================================================
  // tasks
  // keystream x^11 + x^9 + 1, five steps per code group
  function automatic logic [`SCR_WIDTH-1:0] scr5(input logic [`SCR_WIDTH-1:0] st);
    logic [`SCR_WIDTH-1:0] v;
    v = st;
    for (int i = 0; i < 5; i++) v = {v[`SCR_WIDTH-2:0], v[10] ^ v[8]};
    return v;
  endfunction

  task fail(input string msg);
    err_count++;
    $display("Error at %0t ns: %s", $time, msg);
  endtask

  task end_of_test;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // modes change only under reset, so no check straddles two modes
  task setup(input logic [5:0] m);
    @(negedge i_clk_sys);
    i_rst = 1'b1;
    {i_speed_100, i_full_duplex, i_autoneg_en, i_test_loopback, i_oploop_disable} = m[5:1];
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
  endtask

  task mac_frame(input bit loop);
    logic [3:0] v;
    int n;
    n = 4 + ($unsigned($random(seed)) % 8);
    for (int i = 0; i < n; i++) begin
      v = 4'($random(seed));
      if (loop) exp_rx.push_back(v);
      if (!i_speed_100 && !tl_on) exp_ln.push_back(v);
      if (i_speed_100 && !tl_on) exp_sym.push_back((i == 0) ? `SYM_J : (i == 1) ? `SYM_K : code5b[v]);
      mac.send(v, 1'b1);
    end
    if (i_speed_100 && !tl_on) begin
      exp_sym.push_back(`SYM_T);
      exp_sym.push_back(`SYM_R);
    end
    mac.send(4'h0, 1'b0);
  endtask

  // a late wait catches valid nibbles that should never have come
  task drain(input string name);
    for (int k = 0; k < 4000 && exp_rx.size() + exp_ln.size() + exp_sym.size() > 0; k++) @(posedge i_clk_sys);
    repeat (200) @(negedge i_clk_sys);
    n_checks++;
    if (exp_rx.size() + exp_ln.size() + exp_sym.size() != 0) fail("expected nibbles missing");
    exp_rx.delete();
    exp_ln.delete();
    exp_sym.delete();
    $display("test done: %s", name);
  endtask

  // line clock stands still between symbols; released data is inverted
  // edges land on falling system clock edges, midway between rising ones; a 125 ns period when gap is zero
  task line_sym(input logic [4:0] sym, input int gap);
    i_line_rx_sym = sym;
    #10 i_line_rx_clk = 1'b1;
    #60 i_line_rx_clk = 1'b0;
    #5 i_line_rx_sym = ~i_line_rx_sym;
    #(50 + gap);
  endtask

  // ==========================================================================
  // monitors: each valid rx nibble pops the oldest note
  always @(posedge o_rx_clk) begin
    if (o_rx_dv === 1'b1 && !lax) begin
      n_checks++;
      if (exp_rx.size() == 0) begin
        fail("unexpected rx nibble");
      end else begin
        if ({o_rx_er, o_rxd} !== exp_rx[0]) fail("rx nibble mismatch");
        exp_rx.delete(0);
      end
    end
  end

  // 10 Mbps line symbols with the enable bit set carry the captured nibble; 100 Mbps groups are
  // descrambled by our own keystream, restarted at every reset as the line side expects
  always @(negedge i_clk_sys) begin
    stb_q <= o_line_tx_stb;
    saw_full <= lax ? (saw_full | (o_line_rx_ready === 1'b0)) : 1'b0;
    if (i_rst !== 1'b0) begin
      tk = `SCR_SEED;
    end else if (stb_q === 1'b1 && i_speed_100 === 1'b0 && o_line_tx_sym[4] === 1'b1) begin
      n_checks++;
      if (exp_ln.size() == 0 || o_line_tx_sym[3:0] !== exp_ln[0]) fail("line symbol mismatch");
      if (exp_ln.size() != 0) exp_ln.delete(0);
    end else if (stb_q === 1'b1 && i_speed_100 === 1'b1) begin
      lsy = o_line_tx_sym ^ tk[4:0];
      tk = scr5(tk);
      if (exp_sym.size() == 0 || (lsy === `SYM_IDLE && exp_sym[0] == `SYM_J)) begin
        if (lsy !== `SYM_IDLE) fail("line not idle between frames");
      end else begin
        n_checks++;
        if (lsy !== exp_sym[0]) fail("line code group mismatch");
        exp_sym.delete(0);
      end
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(negedge i_clk_sys);
    i_rst = 1'b0;
    // carrier stays high except under operational loopback, to provoke crs and col
    foreach (modes[i]) begin
      setup(modes[i]);
      i_line_rx_carrier = !(modes[i][0] && !modes[i][2]);
      repeat (100) @(negedge i_clk_sys);
      mac_frame(modes[i][0]);
      i_line_rx_carrier = 1'b0;
      drain($sformatf("mode %h", modes[i]));
    end
    // 100 Mbps reception: scrambled J K, four data groups, one invalid group, then T R
    setup(6'h30);
    i_line_rx_carrier = 1'b1;
    rk = `SCR_SEED;
    for (int i = 0; i < 9; i++) begin
      logic [3:0] v;
      logic [4:0] sy;
      v = 4'($random(seed));
      sy = (i == 0) ? `SYM_J : (i == 1) ? `SYM_K : (i < 6) ? code5b[v] : (i == 6) ? 5'h00 : (i == 7) ? `SYM_T : `SYM_R;
      if (i < 7) exp_rx.push_back((i < 2) ? {1'b0, `NIB_PREAMBLE} : (i < 6) ? {1'b0, v} : {1'b1, `NIB_RX_ERROR});
      line_sym(sy ^ rk[4:0], 0);
      rk = scr5(rk);
    end
    i_line_rx_carrier = 1'b0;
    drain("line rx 100");
    // 10 Mbps reception: preamble stripped, valid from the delimiter nibble
    setup(6'h18);
    i_line_rx_carrier = 1'b1;
    for (int i = 0; i < 8; i++) begin
      logic [3:0] v;
      v = (i < 3) ? 4'h5 : (i == 3) ? 4'hD : 4'($random(seed));
      if (i >= 3) exp_rx.push_back(v);
      line_sym({1'b0, v}, 300);
    end
    #1000 i_line_rx_carrier = 1'b0;
    drain("line rx");
    // a burst faster than the mii drains must fill the buffer
    lax = 1'b1;
    i_line_rx_carrier = 1'b1;
    @(negedge i_clk_sys);
    for (int i = 0; i < 8; i++) line_sym({1'b0, (i == 0) ? 4'hD : 4'($random(seed))}, 0);
    n_checks++;
    if (saw_full !== 1'b1) fail("buffer never refused");
    #2000 i_line_rx_carrier = 1'b0;
    #2000 n_checks++;
    if (o_line_rx_ready !== 1'b1) fail("buffer not drained");
    lax = 1'b0;
    $display("test done: buffer");
    end_of_test();
  end

  // watchdog: the sequence needs well under a quarter of this span
  initial begin
    #400000;
    fail("timeout");
    end_of_test();
  end
endmodule

// *** design/mii_phy_side.sv ***
// phy-side mii logic of a 10/100 transceiver: clocks, 4b/5b framing, rx timing, crs/col, loopback
// assumes a 200 MHz system clock; the line side delivers symbols with its own recovered clock,
// and the mac drives txd/tx_en from the tx clock that this block supplies
`timescale 1ns/10ps
`include "mii_phy_regs.svh"

module mii_phy_side #(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // configuration and link status
  input wire logic i_speed_100,
  input wire logic i_full_duplex,
  input wire logic i_autoneg_en,
  input wire logic i_test_loopback,
  input wire logic i_oploop_disable,
  // mii toward the mac
  output logic o_tx_clk,
  output logic o_rx_clk,
  input wire logic [3:0] i_txd,
  input wire logic i_tx_en,
  output logic [3:0] o_rxd,
  output logic o_rx_dv,
  output logic o_rx_er,
  output logic o_crs,
  output logic o_col,
  // line transmit side
  output logic [4:0] o_line_tx_sym,
  output logic o_line_tx_stb,
  output logic o_line_tx_en,
  // line receive side
  input wire logic i_line_rx_clk,
  input wire logic [4:0] i_line_rx_sym,
  input wire logic i_line_rx_carrier,
  output logic o_line_rx_ready
);

  // ===========================================================================
  // helper functions
  // 4b/5b data encoding
  function automatic logic [4:0] enc_nibble(input logic [3:0] n);
    logic [4:0] s;
    s = 5'h1E;
    unique case (n)
      4'h0: s = 5'h1E;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0A;
      4'h5: s = 5'h0B;
      4'h6: s = 5'h0E;
      4'h7: s = 5'h0F;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'hA: s = 5'h16;
      4'hB: s = 5'h17;
      4'hC: s = 5'h1A;
      4'hD: s = 5'h1B;
      4'hE: s = 5'h1C;
      4'hF: s = 5'h1D;
    endcase
    return s;
  endfunction

  // 5b/4b data decoding: bit 4 set means the code group is not a data symbol
  function automatic logic [4:0] dec_symbol(input logic [4:0] s);
    logic [4:0] r;
    r = 5'h10;
    case (s)
      5'h1E: r = 5'h00;
      5'h09: r = 5'h01;
      5'h14: r = 5'h02;
      5'h15: r = 5'h03;
      5'h0A: r = 5'h04;
      5'h0B: r = 5'h05;
      5'h0E: r = 5'h06;
      5'h0F: r = 5'h07;
      5'h12: r = 5'h08;
      5'h13: r = 5'h09;
      5'h16: r = 5'h0A;
      5'h17: r = 5'h0B;
      5'h1A: r = 5'h0C;
      5'h1B: r = 5'h0D;
      5'h1C: r = 5'h0E;
      5'h1D: r = 5'h0F;
      default: r = 5'h10;
    endcase
    return r;
  endfunction

  // five steps of the x^11 + x^9 + 1 keystream generator
  function automatic logic [`SCR_WIDTH-1:0] scr_step(input logic [`SCR_WIDTH-1:0] st);
    logic [`SCR_WIDTH-1:0] v;
    v = st;
    for (int i = 0; i < 5; i++) begin
      v = {v[`SCR_WIDTH-2:0], v[10] ^ v[8]};
    end
    return v;
  endfunction

  // ===========================================================================
  // mii clock divider: one flop feeds both clocks, so tx and rx clocks never drift apart
  logic [6:0] div_cnt_q;
  logic mii_clk_q;
  wire [6:0] half_count = i_speed_100 ? 7'(`MII_FAST_HALF) : 7'(`MII_SLOW_HALF);
  wire div_wrap = (div_cnt_q >= half_count - 7'h01);
  wire mii_rise = div_wrap && !mii_clk_q;
  wire mii_fall = div_wrap && mii_clk_q;

  // a speed change applies to the half period under way, ending it at once if past the new count, so no runt pulse reaches the mac
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_q <= 7'h00;
      mii_clk_q <= 1'b0;
    end else begin
      div_cnt_q <= div_wrap ? 7'h00 : div_cnt_q + 7'h01;
      if (div_wrap) begin
        mii_clk_q <= !mii_clk_q;
      end
    end
  end

  assign o_tx_clk = mii_clk_q;
  assign o_rx_clk = mii_clk_q;

  // ===========================================================================
  // input synchronisers for every pin from outside the system clock domain
  logic [3:0] txd_s1_q, txd_s2_q;
  logic tx_en_s1_q, tx_en_s2_q;
  logic lclk_s1_q, lclk_s2_q, lclk_s3_q;
  logic [4:0] lsym_s1_q, lsym_s2_q;
  logic lcar_s1_q, lcar_s2_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      txd_s1_q <= 4'h0;
      txd_s2_q <= 4'h0;
      tx_en_s1_q <= 1'b0;
      tx_en_s2_q <= 1'b0;
      lclk_s1_q <= 1'b0;
      lclk_s2_q <= 1'b0;
      lclk_s3_q <= 1'b0;
      lsym_s1_q <= 5'h00;
      lsym_s2_q <= 5'h00;
      lcar_s1_q <= 1'b0;
      lcar_s2_q <= 1'b0;
    end else begin
      txd_s1_q <= i_txd;
      txd_s2_q <= txd_s1_q;
      tx_en_s1_q <= i_tx_en;
      tx_en_s2_q <= tx_en_s1_q;
      lclk_s1_q <= i_line_rx_clk;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
      lsym_s1_q <= i_line_rx_sym;
      lsym_s2_q <= lsym_s1_q;
      lcar_s1_q <= i_line_rx_carrier;
      lcar_s2_q <= lcar_s1_q;
    end
  end

  // ===========================================================================
  // transmit capture: the synced copy lags the pin by two cycles, so at the rising tick it
  // still shows what the mac held just before the edge
  logic [3:0] tx_nib_q;
  logic tx_en_q;
  logic tx_tick_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_nib_q <= 4'h0;
      tx_en_q <= 1'b0;
      tx_tick_q <= 1'b0;
    end else begin
      tx_tick_q <= mii_rise;
      if (mii_rise) begin
        tx_nib_q <= txd_s2_q;
        tx_en_q <= tx_en_s2_q;
      end
    end
  end

  // ===========================================================================
  // mode decode
  wire test_loop = i_test_loopback && i_full_duplex && !i_autoneg_en;
  wire op_loop = !i_speed_100 && !i_full_duplex && !i_oploop_disable;
  wire half_duplex = !i_full_duplex;

  // ===========================================================================
  // transmit encoder: the first two nibbles give way to the start delimiter; there is no
  // error input from the mac, so no forced error symbol can ever be emitted
  mii_phy_pkg::tx_state_type tx_state_q, tx_state_d;
  logic [4:0] tx_sym_d;
  logic [4:0] tx_sym_q;
  logic [`SCR_WIDTH-1:0] tx_scr_q;

  always_comb begin
    tx_state_d = tx_state_q;
    tx_sym_d = `SYM_IDLE;
    unique case (tx_state_q)
      mii_phy_pkg::TX_IDLE: begin
        if (tx_en_q) begin
          tx_sym_d = `SYM_J;
          tx_state_d = mii_phy_pkg::TX_SEND_K;
        end
      end
      mii_phy_pkg::TX_SEND_K: begin
        tx_sym_d = `SYM_K;
        tx_state_d = tx_en_q ? mii_phy_pkg::TX_DATA : mii_phy_pkg::TX_SEND_R;
        if (!tx_en_q) begin
          tx_sym_d = `SYM_T; // frame shorter than the delimiter still closes cleanly
        end
      end
      mii_phy_pkg::TX_DATA: begin
        if (tx_en_q) begin
          tx_sym_d = enc_nibble(tx_nib_q);
        end else begin
          tx_sym_d = `SYM_T;
          tx_state_d = mii_phy_pkg::TX_SEND_R;
        end
      end
      mii_phy_pkg::TX_SEND_T: begin
        tx_sym_d = `SYM_T;
        tx_state_d = mii_phy_pkg::TX_SEND_R;
      end
      mii_phy_pkg::TX_SEND_R: begin
        tx_sym_d = `SYM_R;
        tx_state_d = mii_phy_pkg::TX_IDLE;
      end
      default: begin
        tx_state_d = mii_phy_pkg::TX_IDLE;
      end
    endcase
  end

  // line symbols leave one per nibble time; 10 Mbps sends the raw nibble
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_state_q <= mii_phy_pkg::TX_IDLE;
      tx_sym_q <= `SYM_IDLE;
      tx_scr_q <= `SCR_SEED;
    end else if (tx_tick_q) begin
      tx_state_q <= i_speed_100 ? tx_state_d : mii_phy_pkg::TX_IDLE;
      tx_scr_q <= scr_step(tx_scr_q);
      if (i_speed_100) begin
        tx_sym_q <= tx_sym_d ^ tx_scr_q[4:0];
      end else begin
        tx_sym_q <= {tx_en_q, tx_nib_q};
      end
    end
  end

  assign o_line_tx_sym = tx_sym_q;
  assign o_line_tx_stb = tx_tick_q && !test_loop;
  assign o_line_tx_en = !test_loop;

  // ===========================================================================
  // receive decoder on the recovered line clock edges
  logic [`SCR_WIDTH-1:0] rx_scr_q;
  wire line_edge = lclk_s2_q && !lclk_s3_q;
  wire [4:0] rx_plain = i_speed_100 ? (lsym_s2_q ^ rx_scr_q[4:0]) : lsym_s2_q;
  wire [4:0] rx_dec = dec_symbol(rx_plain);
  wire rx_is_data = !rx_dec[4];
  wire rx_is_ctrl = (rx_plain == `SYM_IDLE) || (rx_plain == `SYM_J) || (rx_plain == `SYM_K)
                    || (rx_plain == `SYM_T) || (rx_plain == `SYM_R);
  mii_phy_pkg::rx_state_type rx_state_q, rx_state_d;
  logic sfd_seen_q;
  logic [5:0] rx_word_d;
  logic rx_push_d;

  // entries are {er, dv, nibble}; idle symbols also push a quiet entry to pace the output
  always_comb begin
    rx_state_d = rx_state_q;
    rx_word_d = 6'h00;
    rx_push_d = 1'b0;
    if (i_speed_100) begin
      rx_push_d = line_edge;
      unique case (rx_state_q)
        mii_phy_pkg::RX_IDLE: begin
          if (rx_plain == `SYM_J) begin
            rx_state_d = mii_phy_pkg::RX_GOT_J;
            rx_word_d = {2'b01, `NIB_PREAMBLE};
          end
        end
        mii_phy_pkg::RX_GOT_J: begin
          rx_state_d = (rx_plain == `SYM_K) ? mii_phy_pkg::RX_FRAME : mii_phy_pkg::RX_IDLE;
          rx_word_d = (rx_plain == `SYM_K) ? {2'b01, `NIB_PREAMBLE} : {2'b11, `NIB_RX_ERROR};
        end
        mii_phy_pkg::RX_FRAME: begin
          if (rx_is_data) begin
            rx_word_d = {2'b01, rx_dec[3:0]};
          end else if (rx_is_ctrl) begin
            rx_state_d = mii_phy_pkg::RX_IDLE; // end delimiter or idle closes the frame
          end else begin
            rx_word_d = {2'b11, `NIB_RX_ERROR};
          end
        end
        default: begin
          rx_state_d = mii_phy_pkg::RX_IDLE;
        end
      endcase
    end else begin
      rx_push_d = line_edge;
      if (lcar_s2_q && (sfd_seen_q || lsym_s2_q[3:0] == `NIB_SFD_FIRST)) begin
        rx_word_d = {2'b01, lsym_s2_q[3:0]};
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_state_q <= mii_phy_pkg::RX_IDLE;
      rx_scr_q <= `SCR_SEED;
      sfd_seen_q <= 1'b0;
    end else if (line_edge && o_line_rx_ready) begin
      rx_state_q <= rx_state_d;
      rx_scr_q <= scr_step(rx_scr_q);
      sfd_seen_q <= lcar_s2_q && rx_word_d[4] && !i_speed_100;
    end
  end

  // ===========================================================================
  // source select: either loopback returns the captured tx nibbles instead of line data
  wire loop_on = test_loop || op_loop;
  wire in_valid = loop_on ? tx_tick_q : (rx_push_d && !test_loop);
  wire [5:0] in_word = loop_on ? {1'b0, tx_en_q, tx_nib_q} : rx_word_d;

  // ===========================================================================
  // two-entry buffer; drained at the falling mii edge so the mac sees stable data at its rise
  logic [5:0] fifo_mem_q [FIFO_DEPTH];
  logic [1:0] fifo_cnt_q;
  logic fifo_wr_q, fifo_rd_q;
  wire fifo_full = (fifo_cnt_q == 2'(FIFO_DEPTH));
  wire fifo_empty = (fifo_cnt_q == 2'h0);
  wire out_ready = mii_fall;
  // a full buffer that drains in this cycle still takes the word, as ready has promised
  wire do_push = in_valid && (!fifo_full || out_ready);
  wire do_pop = out_ready && !fifo_empty;

  assign o_line_rx_ready = !fifo_full || out_ready;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fifo_cnt_q <= 2'h0;
      fifo_wr_q <= 1'b0;
      fifo_rd_q <= 1'b0;
    end else begin
      fifo_cnt_q <= fifo_cnt_q + 2'(do_push) - 2'(do_pop);
      fifo_wr_q <= fifo_wr_q ^ do_push;
      fifo_rd_q <= fifo_rd_q ^ do_pop;
    end
  end

  // storage holds data only, so it needs no reset
  always_ff @(posedge i_clk_sys) begin
    if (do_push) begin
      fifo_mem_q[fifo_wr_q] <= in_word;
    end
  end

  // ===========================================================================
  // mii receive outputs, updated only on the falling rx clock edge
  logic [3:0] rxd_q;
  logic rx_dv_q, rx_er_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rxd_q <= 4'h0;
      rx_dv_q <= 1'b0;
      rx_er_q <= 1'b0;
    end else if (out_ready) begin
      rxd_q <= fifo_empty ? 4'h0 : fifo_mem_q[fifo_rd_q][3:0];
      rx_dv_q <= !fifo_empty && fifo_mem_q[fifo_rd_q][4];
      rx_er_q <= !fifo_empty && fifo_mem_q[fifo_rd_q][5];
    end
  end

  assign o_rxd = rxd_q;
  assign o_rx_dv = rx_dv_q;
  assign o_rx_er = rx_er_q;

  // ===========================================================================
  // carrier and collision: plain gates of the synced activity, no mii clock involved,
  // so they follow the line within the synchroniser delay at either speed
  wire line_rx_act = lcar_s2_q && !test_loop;
  wire mac_tx_act = tx_en_s2_q;
  assign o_crs = line_rx_act || (half_duplex && mac_tx_act);
  assign o_col = half_duplex && line_rx_act && mac_tx_act;

endmodule

// *** shared/mii_phy_pkg.sv ***
// types for the phy-side mii block
// assumes nothing of its surroundings
package mii_phy_pkg;

  // ===========================================================================
  // transmit encoder states
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_SEND_K = 3'h1,
    TX_DATA = 3'h2,
    TX_SEND_T = 3'h3,
    TX_SEND_R = 3'h4
  } tx_state_type;

  // ===========================================================================
  // receive decoder states (100 Mbps)
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_GOT_J = 2'h1,
    RX_FRAME = 2'h2
  } rx_state_type;

endpackage

// *** shared/mii_phy_regs.svh ***
// constants for the phy-side mii block: clock rates, divider counts, code groups
// assumes the system clock runs at 200 MHz; rates are in hz, half periods in system cycles, codes are raw bits
`ifndef MII_PHY_REGS_SVH
`define MII_PHY_REGS_SVH

// ===========================================================================
// clock rates
`define SYS_CLK_HZ 200000000
`define MII_FAST_HZ 25000000
`define MII_SLOW_HZ 2500000
// half periods of the mii clocks in system cycles (round down, at least one)
`define MII_FAST_HALF ((`SYS_CLK_HZ / `MII_FAST_HZ) / 2)
`define MII_SLOW_HALF ((`SYS_CLK_HZ / `MII_SLOW_HZ) / 2)

// ===========================================================================
// 5-bit code groups
`define SYM_IDLE 5'h1F
`define SYM_J 5'h18
`define SYM_K 5'h11
`define SYM_T 5'h0D
`define SYM_R 5'h07

// ===========================================================================
// nibble values
`define NIB_PREAMBLE 4'h5
`define NIB_SFD_FIRST 4'hD
`define NIB_RX_ERROR 4'h5

// ===========================================================================
// scrambler
`define SCR_WIDTH 11
`define SCR_SEED 11'h7FF

`endif
